// ### bench/dasp_station.sv
// dasp_station: remote serial station on one line
module dasp_station (
    // clock
    input wire logic mclk,
    // line
    input wire logic txd,
    output logic rxd
);
    timeunit 1ns;
    timeprecision 1ns;
    import dasp_pkg::*;
    initial rxd = 1'b1;
    task automatic send(input dasp_byte_type b, input logic nb,
        input logic nine, input int clks);
        logic [10:0] f;
        int n;
        f = nine ? {1'b1, nb, b, 1'b0} : {2'b11, b, 1'b0};
        n = nine ? 11 : 10;
        @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            rxd <= f[i];
            repeat (clks) @(posedge mclk);
        end
    endtask : send
    // bad start or stop poisons the byte so the compare fails
    task automatic recv(output dasp_byte_type b, output logic nb,
        input logic nine, input int clks);
        int t;
        b = 'x;
        nb = 1'bx;
        t = 0;
        while (txd && t < 4000) begin
            @(posedge mclk);
            t++;
        end
        repeat (clks / 2) @(posedge mclk);
        if (txd) return;
        for (int i = 0; i < 8; i++) begin
            repeat (clks) @(posedge mclk);
            b[i] = txd;
        end
        if (nine) begin
            repeat (clks) @(posedge mclk);
            nb = txd;
        end
        repeat (clks) @(posedge mclk);
        if (!txd) b = 'x;
    endtask : recv
endmodule : dasp_station

// ### bench/dasp_top_monitor.sv
// dasp_top_monitor: port-level properties of the dual serial port
module dasp_top_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire dasp_pkg::dasp_byte_type reg_addr,
    input wire dasp_pkg::dasp_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire dasp_pkg::dasp_byte_type reg_rdata,
    // rate source and lines
    input wire logic timer1_ovf,
    input wire logic rxd0,
    input wire logic txd0,
    input wire logic rxd1,
    input wire logic txd1
);
    timeunit 1ns;
    timeprecision 1ns;
    import dasp_pkg::*;
    // ----------------------------------------
    // shadow of settings the frame checks need
    // ----------------------------------------
    logic [1:0] p0m;
    logic dbl;
    logic [9:0] rel1;
    dasp_byte_type tx0b;
    dasp_byte_type tx1b;
    wire logic wr0 = reg_wr && reg_addr == DASP_PORT0_BUF;
    wire logic wr1 = reg_wr && reg_addr == DASP_PORT1_BUF;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p0m <= DASP_MODE0;
            dbl <= 1'b0;
            rel1 <= 10'h000;
            tx0b <= DASP_RESET_VAL;
            tx1b <= DASP_RESET_VAL;
        end else if (reg_wr) begin
            if (reg_addr == DASP_PORT0_CTRL) p0m <= reg_wdata[7:6];
            if (reg_addr == DASP_RATE_CFG) dbl <= reg_wdata[6];
            if (reg_addr == DASP_PORT1_RELL) rel1[7:0] <= reg_wdata;
            if (reg_addr == DASP_PORT1_RELH) rel1[9:8] <= reg_wdata[1:0];
            if (wr0) tx0b <= reg_wdata;
            if (wr1) tx1b <= reg_wdata;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_rd_quiet;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet)
        else $error("read data not zero outside read slot");
    property p_rel_back;
        reg_wr && reg_addr == DASP_PORT0_RELL ##2
        reg_rd && reg_addr == DASP_PORT0_RELL
        |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_rel_back: assert property (p_rel_back)
        else $error("reload low did not read back");
    property p_p1_rsv;
        reg_rd && reg_addr == DASP_PORT1_CTRL |=> !reg_rdata[6];
    endproperty
    a_p1_rsv: assert property (p_p1_rsv)
        else $error("port 1 control bit 6 not zero");
    property p_rate_rsv;
        reg_rd && reg_addr == DASP_RATE_CFG |=> reg_rdata[5:0] == 6'h00;
    endproperty
    a_rate_rsv: assert property (p_rate_rsv)
        else $error("rate config low bits not zero");
    property p_relh_rsv;
        reg_rd && (reg_addr == DASP_PORT0_RELH ||
        reg_addr == DASP_PORT1_RELH) |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_relh_rsv: assert property (p_relh_rsv)
        else $error("reload high upper bits not zero");
    property p_mode0_idle;
        p0m == DASP_MODE0 |-> txd0;
    endproperty
    a_mode0_idle: assert property (p_mode0_idle)
        else $error("port 0 line active in mode 0");
    property p_p0_frame;
        wr0 && p0m == DASP_MODE2 && dbl && txd0 |-> ##[1:4] $fell(txd0)
        ##32 txd0 == tx0b[0] ##32 txd0 == tx0b[1];
    endproperty
    a_p0_frame: assert property (p_p0_frame)
        else $error("port 0 fixed rate frame timing wrong");
    property p_p1_frame;
        wr1 && rel1 == 10'h3FF && txd1 |-> ##[1:4] $fell(txd1)
        ##32 txd1 == tx1b[0] ##32 txd1 == tx1b[1];
    endproperty
    a_p1_frame: assert property (p_p1_frame)
        else $error("port 1 generator frame timing wrong");
    c_p0_tx: cover property (wr0 && p0m == DASP_MODE2);
    c_p1_rx: cover property ($fell(rxd1));
    c_p0_rx: cover property ($fell(rxd0));
endmodule : dasp_top_monitor

bind dasp_top dasp_top_monitor u_mon (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer1_ovf(timer1_ovf),
    .rxd0(rxd0), .txd0(txd0), .rxd1(rxd1), .txd1(txd1));

// ### bench/dasp_top_test.sv
// dasp_top_test: register and line tests of the dual serial port
module dasp_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dasp_pkg::*;
    localparam int BIT = 32;
    logic mclk, rst_n, reg_wr, reg_rd, txd0, txd1, rxd0, rxd1, nb, t1;
    dasp_byte_type reg_addr, reg_wdata, reg_rdata, got;
    int errors, n_tests;
    dasp_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer1_ovf(t1), .rxd0(rxd0),
        .txd0(txd0), .rxd1(rxd1), .txd1(txd1));
    dasp_station st0 (.mclk(mclk), .txd(txd0), .rxd(rxd0));
    dasp_station st1 (.mclk(mclk), .txd(txd1), .rxd(rxd1));
    always #50 mclk = ~mclk;
    always @(posedge mclk) t1 <= !t1;
    task automatic check(input dasp_byte_type g, input dasp_byte_type e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : check
    task automatic wr(input dasp_byte_type a, input dasp_byte_type d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input dasp_byte_type a, input dasp_byte_type e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, e);
    endtask : rd
    task automatic rx_case(input bit p, input dasp_byte_type b,
        input logic n9, input logic nine, input dasp_byte_type ec,
        input dasp_byte_type eb);
        if (p) st1.send(b, n9, nine, BIT);
        else st0.send(b, n9, nine, BIT);
        rd(p ? DASP_PORT1_CTRL : DASP_PORT0_CTRL, ec);
        rd(p ? DASP_PORT1_BUF : DASP_PORT0_BUF, eb);
    endtask : rx_case
    task automatic wrap_up;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        t1 = 1'b0;
        errors = 0;
        n_tests = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(DASP_PORT0_CTRL, DASP_RESET_VAL);
        wr(DASP_PORT0_BUF, 8'h00);
        rd(8'h00, 8'h00);
        wr(DASP_RATE_CFG, 8'hFF);
        rd(DASP_RATE_CFG, DASP_RATE_MASK);
        wr(DASP_PORT0_RELL, 8'hFF);
        rd(DASP_PORT0_RELL, 8'hFF);
        wr(DASP_PORT0_RELH, 8'hFF);
        rd(DASP_PORT0_RELH, 8'h03);
        wr(DASP_PORT1_RELL, 8'hFF);
        wr(DASP_PORT1_RELH, 8'h03);
        // reloads apply only after each generator wraps once
        repeat (1024) @(posedge mclk);
        wr(DASP_PORT1_CTRL, 8'h58);
        rd(DASP_PORT1_CTRL, 8'h18);
        wr(DASP_PORT0_CTRL, 8'h88);
        wr(DASP_PORT0_BUF, 8'hA5);
        st0.recv(got, nb, 1'b1, BIT);
        check(got, 8'hA5);
        check({7'h00, nb}, 8'h01);
        repeat (BIT) @(posedge mclk);
        rd(DASP_PORT0_CTRL, 8'h8A);
        wr(DASP_PORT0_CTRL, 8'hD0);
        rd(DASP_PORT0_CTRL, 8'hD0);
        wr(DASP_PORT1_BUF, 8'h96);
        st1.recv(got, nb, 1'b1, BIT);
        check(got, 8'h96);
        check({7'h00, nb}, 8'h01);
        rx_case(1'b0, 8'h3C, 1'b1, 1'b1, 8'hD5, 8'h3C);
        wr(DASP_PORT0_CTRL, 8'hF0);
        rx_case(1'b0, 8'h11, 1'b0, 1'b1, 8'hF0, 8'h3C);
        rx_case(1'b0, 8'h22, 1'b1, 1'b1, 8'hF5, 8'h22);
        wr(DASP_PORT0_CTRL, 8'hC0);
        rx_case(1'b0, 8'h55, 1'b1, 1'b1, 8'hC0, 8'h22);
        rx_case(1'b1, 8'h5A, 1'b0, 1'b1, 8'h1B, 8'h5A);
        wr(DASP_PORT1_CTRL, 8'h90);
        rx_case(1'b1, 8'hC3, 1'b0, 1'b0, 8'h95, 8'hC3);
        wr(DASP_PORT1_BUF, 8'h7E);
        st1.recv(got, nb, 1'b0, BIT);
        check(got, 8'h7E);
        wr(DASP_RATE_CFG, 8'h40);
        wr(DASP_PORT0_CTRL, 8'h50);
        rx_case(1'b0, 8'h96, 1'b0, 1'b0, 8'h55, 8'h96);
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        wrap_up;
    end
endmodule : dasp_top_test

// ### hw/dasp_engine.sv
// dasp_engine: transmit and receive shifters of one serial port
module dasp_engine (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic active,
    input wire logic tick,
    input wire logic nine,
    input wire logic mp_en,
    input wire logic rx_en,
    // transmit side
    input wire logic tx_start,
    input wire dasp_pkg::dasp_byte_type tx_byte,
    input wire logic tx_ninth,
    output logic txd,
    output logic tx_done,
    // receive side
    input wire logic rxd,
    output logic rx_done,
    output dasp_pkg::dasp_byte_type rx_byte,
    output logic rx_ninth
);
    import dasp_pkg::*;

    dasp_tx_state_type tx_state;
    dasp_rx_state_type rx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_phase;
    logic [3:0] tx_left;
    logic [9:0] rx_shift;
    logic [3:0] rx_phase;
    logic [3:0] rx_left;

    wire logic tx_end = tick && (tx_phase == DASP_OVS_LAST);
    wire logic rx_mid = tick && (rx_phase == DASP_OVS_MID);
    wire logic [9:0] rx_word = {rxd, rx_shift[9:1]};
    wire logic rx_bit9 = nine ? rx_word[8] : rx_word[9];
    wire dasp_byte_type rx_data = nine ? rx_word[7:0] : rx_word[8:1];
    wire logic rx_accept = !mp_en || rx_bit9;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state <= DASP_TX_IDLE;
            tx_shift <= '1;
            tx_phase <= '0;
            tx_left <= '0;
            txd <= 1'b1;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            unique case (tx_state)
                DASP_TX_IDLE: begin
                    txd <= 1'b1;
                    tx_phase <= '0;
                    if (tx_start && active) begin
                        tx_state <= DASP_TX_SEND;
                        // stop, ninth or second stop, data, start
                        tx_shift <= {1'b1, nine ? tx_ninth : 1'b1,
                                     tx_byte, 1'b0};
                        tx_left <= nine ? DASP_TX_NINE : DASP_TX_EIGHT;
                    end
                end
                DASP_TX_SEND: begin
                    if (tick) begin
                        txd <= tx_shift[0];
                        tx_phase <= tx_phase + 4'h1;
                    end
                    if (tx_end) begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_left <= tx_left - 4'h1;
                        if (tx_left == DASP_LEFT_ONE) begin
                            tx_state <= DASP_TX_IDLE;
                            tx_done <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= DASP_RX_IDLE;
            rx_shift <= '0;
            rx_phase <= '0;
            rx_left <= '0;
            rx_done <= 1'b0;
            rx_byte <= '0;
            rx_ninth <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_phase <= rx_phase + 4'h1;
            end
            unique case (rx_state)
                DASP_RX_IDLE: begin
                    rx_phase <= '0;
                    // low line at a tick while enabled opens a frame
                    if (tick && active && rx_en && !rxd) begin
                        rx_state <= DASP_RX_START;
                        rx_left <= nine ? DASP_RX_NINE : DASP_RX_EIGHT;
                    end
                end
                DASP_RX_START: begin
                    // a glitch that is high again at mid-bit is dropped
                    if (rx_mid) begin
                        rx_state <= rxd ? DASP_RX_IDLE : DASP_RX_DATA;
                    end
                end
                DASP_RX_DATA: begin
                    if (!rx_en) begin
                        rx_state <= DASP_RX_IDLE;
                    end else if (rx_mid) begin
                        rx_shift <= rx_word;
                        rx_left <= rx_left - 4'h1;
                        if (rx_left == DASP_LEFT_ONE) begin
                            rx_state <= DASP_RX_IDLE;
                            rx_done <= rx_accept;
                            if (rx_accept) begin
                                rx_byte <= rx_data;
                                rx_ninth <= rx_bit9;
                            end
                        end
                    end
                end
                default: begin
                    rx_state <= DASP_RX_IDLE;
                end
            endcase
        end
    end

endmodule : dasp_engine

// ### hw/dasp_pkg.sv
// dasp_pkg: register map, field positions, states and frame constants
package dasp_pkg;

    typedef logic [7:0] dasp_byte_type;

    // ------------------------------------------------------------
    // register offsets, reset value and read masks
    // ------------------------------------------------------------
    localparam dasp_byte_type DASP_PORT0_CTRL = 8'h9B;
    localparam dasp_byte_type DASP_PORT0_BUF = 8'h99;
    localparam dasp_byte_type DASP_PORT1_CTRL = 8'h9C;
    localparam dasp_byte_type DASP_PORT1_BUF = 8'h9D;
    localparam dasp_byte_type DASP_PORT0_RELL = 8'hAA;
    localparam dasp_byte_type DASP_PORT0_RELH = 8'hBA;
    localparam dasp_byte_type DASP_PORT1_RELL = 8'h9E;
    localparam dasp_byte_type DASP_PORT1_RELH = 8'hBB;
    localparam dasp_byte_type DASP_RATE_CFG = 8'hD8;
    localparam dasp_byte_type DASP_RESET_VAL = 8'h00;
    localparam dasp_byte_type DASP_PORT1_MASK = 8'hBF;
    localparam dasp_byte_type DASP_RATE_MASK = 8'hC0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DASP_F_MODE_HI = 7;
    localparam int DASP_F_MODE_LO = 6;
    localparam int DASP_F_MP = 5;
    localparam int DASP_F_REN = 4;
    localparam int DASP_F_TB8 = 3;
    localparam int DASP_F_RB8 = 2;
    localparam int DASP_F_TI = 1;
    localparam int DASP_F_RI = 0;
    localparam int DASP_F_GEN_SEL = 7;
    localparam int DASP_F_DOUBLE = 6;

    // ------------------------------------------------------------
    // modes, timing and frame counts
    // ------------------------------------------------------------
    localparam logic [1:0] DASP_MODE0 = 2'h0;
    localparam logic [1:0] DASP_MODE2 = 2'h2;
    localparam logic [1:0] DASP_DIV_1 = 2'h0;
    localparam logic [1:0] DASP_DIV_2 = 2'h1;
    localparam logic [1:0] DASP_DIV_4 = 2'h3;
    localparam logic [9:0] DASP_GEN_TOP = 10'h3FF;
    localparam logic [3:0] DASP_OVS_LAST = 4'hF;
    localparam logic [3:0] DASP_OVS_MID = 4'h7;
    localparam logic [3:0] DASP_TX_NINE = 4'hB;
    localparam logic [3:0] DASP_TX_EIGHT = 4'hA;
    localparam logic [3:0] DASP_RX_NINE = 4'hA;
    localparam logic [3:0] DASP_RX_EIGHT = 4'h9;
    localparam logic [3:0] DASP_LEFT_ONE = 4'h1;

    typedef enum logic {DASP_TX_IDLE, DASP_TX_SEND} dasp_tx_state_type;
    typedef enum logic [1:0] {
        DASP_RX_IDLE,
        DASP_RX_START,
        DASP_RX_DATA
    } dasp_rx_state_type;

endpackage : dasp_pkg

// ### hw/dasp_top.sv
// dasp_top: two asynchronous serial ports behind a byte register port
module dasp_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire dasp_pkg::dasp_byte_type reg_addr,
    input wire dasp_pkg::dasp_byte_type reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output dasp_pkg::dasp_byte_type reg_rdata,
    // rate source
    input wire logic timer1_ovf,
    // serial line, port 0
    input wire logic rxd0,
    output logic txd0,
    // serial line, port 1
    input wire logic rxd1,
    output logic txd1
);
    import dasp_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_core_n;
    dasp_byte_type port0_ctrl_reg;
    dasp_byte_type port1_ctrl_reg;
    dasp_byte_type rate_cfg_reg;
    dasp_byte_type port0_buffer;
    dasp_byte_type port1_buffer;
    dasp_byte_type port0_tx_byte;
    dasp_byte_type port1_tx_byte;
    logic [9:0] port0_reload;
    logic [9:0] port1_reload;
    logic [9:0] gen0_count;
    logic [9:0] gen1_count;
    logic [1:0] pre0_count;
    logic [1:0] pre1_count;
    logic tx0_done;
    logic tx1_done;
    logic rx0_done;
    logic rx1_done;
    logic rx0_ninth;
    logic rx1_ninth;
    dasp_byte_type rx0_byte;
    dasp_byte_type rx1_byte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bit 10 flags the overflow that reloads the counter
    function automatic logic [10:0] gen_step(input logic [9:0] cnt,
                                             input logic [9:0] rel);
        if (cnt == DASP_GEN_TOP) begin
            return {1'b1, rel};
        end
        return {1'b0, cnt + 10'h001};
    endfunction : gen_step

    function automatic logic [1:0] pre_step(input logic [1:0] cnt,
                                            input logic [1:0] last);
        if (cnt == last) begin
            return 2'h0;
        end
        return cnt + 2'h1;
    endfunction : pre_step

    // hardware events win over a software write in the same cycle
    function automatic dasp_byte_type ctrl_next(
        input dasp_byte_type cur,
        input logic wr,
        input dasp_byte_type wdata,
        input logic tx_set,
        input logic rx_set,
        input logic ninth
    );
        dasp_byte_type val;
        val = wr ? wdata : cur;
        if (tx_set) begin
            val[DASP_F_TI] = 1'b1;
        end
        if (rx_set) begin
            val[DASP_F_RI] = 1'b1;
            val[DASP_F_RB8] = ninth;
        end
        return val;
    endfunction : ctrl_next

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_core_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_core_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // field and address decode
    // ------------------------------------------------------------
    wire logic port0_mode_hi = port0_ctrl_reg[DASP_F_MODE_HI];
    wire logic port0_mode_lo = port0_ctrl_reg[DASP_F_MODE_LO];
    wire logic [1:0] port0_mode = {port0_mode_hi, port0_mode_lo};
    wire logic port0_multiproc_en = port0_ctrl_reg[DASP_F_MP];
    wire logic port0_rx_enable = port0_ctrl_reg[DASP_F_REN];
    wire logic port0_tx_ninth = port0_ctrl_reg[DASP_F_TB8];
    wire logic port1_mode_sel = port1_ctrl_reg[DASP_F_MODE_HI];
    wire logic port1_multiproc_en = port1_ctrl_reg[DASP_F_MP];
    wire logic port1_rx_enable = port1_ctrl_reg[DASP_F_REN];
    wire logic port1_tx_ninth = port1_ctrl_reg[DASP_F_TB8];
    wire logic gen_select = rate_cfg_reg[DASP_F_GEN_SEL];
    wire logic rate_double = rate_cfg_reg[DASP_F_DOUBLE];

    // mode 0 shift register operation is not built
    wire logic port0_active = port0_mode != DASP_MODE0;
    wire logic port0_nine = port0_mode_hi;
    wire logic port0_fixed = port0_mode == DASP_MODE2;
    wire logic port1_nine = !port1_mode_sel;

    wire logic wr_p0_ctrl = reg_wr && (reg_addr == DASP_PORT0_CTRL);
    wire logic wr_p0_buf = reg_wr && (reg_addr == DASP_PORT0_BUF);
    wire logic wr_p1_ctrl = reg_wr && (reg_addr == DASP_PORT1_CTRL);
    wire logic wr_p1_buf = reg_wr && (reg_addr == DASP_PORT1_BUF);
    wire logic wr_p0_rell = reg_wr && (reg_addr == DASP_PORT0_RELL);
    wire logic wr_p0_relh = reg_wr && (reg_addr == DASP_PORT0_RELH);
    wire logic wr_p1_rell = reg_wr && (reg_addr == DASP_PORT1_RELL);
    wire logic wr_p1_relh = reg_wr && (reg_addr == DASP_PORT1_RELH);
    wire logic wr_rate = reg_wr && (reg_addr == DASP_RATE_CFG);

    // ------------------------------------------------------------
    // baud generators
    // ------------------------------------------------------------
    // overflow every (1024 - reload) clocks
    wire logic [10:0] gen0_next = gen_step(gen0_count, port0_reload);
    wire logic [10:0] gen1_next = gen_step(gen1_count, port1_reload);
    wire logic gen0_ovf = gen0_next[10];
    wire logic gen1_ovf = gen1_next[10];

    // port 0 source: clock itself in mode 2, else generator or timer 1
    wire logic src0 = port0_fixed ? 1'b1
                    : (gen_select ? gen0_ovf : timer1_ovf);
    // sixteen ticks per bit: clock/4 or /2, generator /4 or /2,
    // timer 1 overflow /2 or /1
    wire logic [1:0] last0 = (port0_fixed || gen_select)
                           ? (rate_double ? DASP_DIV_2 : DASP_DIV_4)
                           : (rate_double ? DASP_DIV_1 : DASP_DIV_2);
    wire logic [1:0] next_pre0 = pre_step(pre0_count, last0);
    wire logic tick0 = src0 && (pre0_count == last0);

    // port 1 never looks at timer 1
    wire logic src1 = gen1_ovf;
    wire logic [1:0] next_pre1 = pre_step(pre1_count, DASP_DIV_2);
    wire logic tick1 = src1 && (pre1_count == DASP_DIV_2);

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            gen0_count <= '0;
            gen1_count <= '0;
        end else begin
            gen0_count <= gen0_next[9:0];
            gen1_count <= gen1_next[9:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pre0_count <= '0;
            pre1_count <= '0;
        end else begin
            if (src0) begin
                pre0_count <= next_pre0;
            end
            if (src1) begin
                pre1_count <= next_pre1;
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    wire dasp_byte_type next_p0_ctrl = ctrl_next(port0_ctrl_reg,
        wr_p0_ctrl, reg_wdata, tx0_done, rx0_done, rx0_ninth);
    wire dasp_byte_type next_p1_ctrl = ctrl_next(port1_ctrl_reg,
        wr_p1_ctrl, reg_wdata, tx1_done, rx1_done, rx1_ninth);

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            port0_ctrl_reg <= DASP_RESET_VAL;
            port1_ctrl_reg <= DASP_RESET_VAL;
        end else begin
            port0_ctrl_reg <= next_p0_ctrl;
            port1_ctrl_reg <= next_p1_ctrl & DASP_PORT1_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            rate_cfg_reg <= DASP_RESET_VAL;
        end else if (wr_rate) begin
            rate_cfg_reg <= reg_wdata & DASP_RATE_MASK;
        end
    end

    // reload changes take effect at the next overflow
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            port0_reload <= '0;
            port1_reload <= '0;
        end else begin
            if (wr_p0_rell) begin
                port0_reload[7:0] <= reg_wdata;
            end
            if (wr_p0_relh) begin
                port0_reload[9:8] <= reg_wdata[1:0];
            end
            if (wr_p1_rell) begin
                port1_reload[7:0] <= reg_wdata;
            end
            if (wr_p1_relh) begin
                port1_reload[9:8] <= reg_wdata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // data buffers
    // ------------------------------------------------------------
    // receive side only; a new frame overwrites an unread byte
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            port0_buffer <= DASP_RESET_VAL;
            port1_buffer <= DASP_RESET_VAL;
        end else begin
            if (rx0_done) begin
                port0_buffer <= rx0_byte;
            end
            if (rx1_done) begin
                port1_buffer <= rx1_byte;
            end
        end
    end

    assign port0_tx_byte = reg_wdata;
    assign port1_tx_byte = reg_wdata;

    // ------------------------------------------------------------
    // serial engines
    // ------------------------------------------------------------
    dasp_engine u_port0 (
        .clk(mclk),
        .rst_n(rst_core_n),
        .active(port0_active),
        .tick(tick0),
        .nine(port0_nine),
        .mp_en(port0_multiproc_en),
        .rx_en(port0_rx_enable),
        .tx_start(wr_p0_buf),
        .tx_byte(port0_tx_byte),
        .tx_ninth(port0_tx_ninth),
        .txd(txd0),
        .tx_done(tx0_done),
        .rxd(rxd0),
        .rx_done(rx0_done),
        .rx_byte(rx0_byte),
        .rx_ninth(rx0_ninth)
    );

    dasp_engine u_port1 (
        .clk(mclk),
        .rst_n(rst_core_n),
        .active(1'b1),
        .tick(tick1),
        .nine(port1_nine),
        .mp_en(port1_multiproc_en),
        .rx_en(port1_rx_enable),
        .tx_start(wr_p1_buf),
        .tx_byte(port1_tx_byte),
        .tx_ninth(port1_tx_ninth),
        .txd(txd1),
        .tx_done(tx1_done),
        .rxd(rxd1),
        .rx_done(rx1_done),
        .rx_byte(rx1_byte),
        .rx_ninth(rx1_ninth)
    );

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    wire dasp_byte_type p0_relh_rd = {6'h00, port0_reload[9:8]};
    wire dasp_byte_type p1_relh_rd = {6'h00, port1_reload[9:8]};
    wire dasp_byte_type read_value =
        (reg_addr == DASP_PORT0_CTRL) ? port0_ctrl_reg :
        (reg_addr == DASP_PORT0_BUF) ? port0_buffer :
        (reg_addr == DASP_PORT1_CTRL) ? port1_ctrl_reg :
        (reg_addr == DASP_PORT1_BUF) ? port1_buffer :
        (reg_addr == DASP_PORT0_RELL) ? port0_reload[7:0] :
        (reg_addr == DASP_PORT0_RELH) ? p0_relh_rd :
        (reg_addr == DASP_PORT1_RELL) ? port1_reload[7:0] :
        (reg_addr == DASP_PORT1_RELH) ? p1_relh_rd :
        (reg_addr == DASP_RATE_CFG) ? rate_cfg_reg :
        DASP_RESET_VAL;

    // data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            reg_rdata <= DASP_RESET_VAL;
        end else begin
            reg_rdata <= reg_rd ? read_value : DASP_RESET_VAL;
        end
    end

endmodule : dasp_top
